// [bench/core_clock_pll_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module core_clock_pll_control_tb;
    import clock_ctrl_pkg::*;
    localparam int LOSS = 1500;
    logic              pclk, presetn, psel, penable, pwrite, sleep_req, irq_active, present;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rdat;
    logic              pready, pslverr, rerr, xtal_in, pll_tick;
    logic              core_tick, core_halt, osc_run, pll_locked;
    int                n_errors, cmp_count, per;

    core_clock_pll_control #(.LOSS_LIMIT(LOSS)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xtal_in(xtal_in), .pll_tick(pll_tick),
        .sleep_req(sleep_req), .irq_active(irq_active), .core_tick(core_tick),
        .core_halt(core_halt), .osc_run(osc_run), .pll_locked(pll_locked));

    xtal_model #(.HALF(512)) xtal (
        .pclk(pclk), .presetn(presetn), .present(present),
        .xtal_in(xtal_in), .pll_tick(pll_tick));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic timed_out(input string what);
        n_errors++;
        $display("mismatch %s expected event seen timeout", what);
        tally_and_finish();
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int i;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) timed_out("pready");
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [31:0] d);
        apb(1'b1, CTRL_ADDR, d);
    endtask

    task automatic rd(input logic [31:0] exp);
        apb(1'b0, CTRL_ADDR, 32'h0000_0000);
        chk("control register", exp, rdat);
        chk("read error", 32'h0, {31'h0, rerr});
    endtask

    task automatic meas(output int n);
        int i;
        for (i = 0; i < 600; i++) begin
            @(posedge pclk);
            if (core_tick === 1'b1) break;
        end
        if (i == 600) timed_out("core_tick");
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (core_tick !== 1'b1 && n < 600);
    endtask

    // First period after a change may still run at the old rate
    task automatic period(input int exp);
        meas(per);
        meas(per);
        chk("core period", exp, per);
    endtask

    task automatic wait_hi(input int halt_sel, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge pclk);
            if ((halt_sel != 0 ? core_halt : pll_locked) === 1'b1) break;
        end
        if (i == lim) timed_out(halt_sel != 0 ? "core_halt" : "pll_locked");
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    initial begin
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = '0;
        pwdata     = '0;
        sleep_req  = 1'b0;
        irq_active = 1'b0;
        present    = 1'b1;
        n_errors   = 0;
        cmp_count  = 0;
        do_reset();
        chk("osc_run", 1, osc_run);
        rd(32'h03);
        wait_hi(0, 4000);
        rd(32'h43);
        wr(32'hCF);
        rd(32'hCF);
        wr(32'h00);
        rd(32'h40);
        apb(1'b1, 12'h004, 32'h07);
        chk("unmapped write error", 32'h1, {31'h0, rerr});
        apb(1'b0, 12'h004, 32'h00);
        chk("unmapped read data", 32'h0, rdat);
        rd(32'h40);
        for (int c = 0; c < 8; c++) begin
            wr(32'(c));
            period(2 << c);
        end
        wr(32'h0B);
        irq_active <= 1'b1;
        period(2);
        irq_active <= 1'b0;
        period(16);
        wr(32'h03);
        irq_active <= 1'b1;
        period(16);
        irq_active <= 1'b0;
        wr(32'h83);
        sleep_req <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("osc_run halted", 0, osc_run);
        wr(32'h03);
        repeat (3) @(posedge pclk);
        chk("osc_run kept", 1, osc_run);
        sleep_req <= 1'b0;
        present   <= 1'b0;
        wait_hi(1, 3000);
        per = 0;
        repeat (300) begin
            @(posedge pclk);
            if (core_tick === 1'b1) per++;
        end
        chk("ticks while halted", 0, per);
        do_reset();
        repeat (4000) @(posedge pclk);
        chk("pll_locked free run", 0, pll_locked);
        chk("core_halt free run", 0, core_halt);
        rd(32'h03);
        period(16);
        tally_and_finish();
    end
endmodule // core_clock_pll_control_tb
`default_nettype wire

// [bench/xtal_model.sv]
`timescale 1ns/1ps
`default_nettype none
module xtal_model #(
    parameter int HALF = 512
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic present,
    output var  logic xtal_in,
    output var  logic pll_tick
);
    int cnt;

    // Loop tick every second pclk, so 512 ticks per crystal period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_tick <= 1'b0;
        end else begin
            pll_tick <= ~pll_tick;
        end
    end

    // A missing crystal does not oscillate: the pin stands still low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt     <= 0;
            xtal_in <= 1'b0;
        end else if (!present) begin
            cnt     <= 0;
            xtal_in <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt     <= 0;
            xtal_in <= ~xtal_in;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // xtal_model
`default_nettype wire

// [verilog/clock_ctrl_pkg.sv]
`default_nettype none
package clock_ctrl_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DIV_W  = 3;
    localparam int unsigned CNT_W  = 7;

    localparam logic [11:0] CTRL_ADDR = 12'h000;

    localparam int unsigned OSC_HALT_BIT = 7;
    localparam int unsigned LOCK_BIT     = 6;
    localparam int unsigned FAST_IRQ_CLOCKING_BIT     = 3;
    localparam int unsigned DIV_MSB      = 2;
    localparam int unsigned DIV_LSB      = 0;

    localparam logic [2:0] DIV_RESET      = 3'h3;
    localparam logic       OSC_HALT_RESET = 1'b0;
    localparam logic       FAST_IRQ_CLOCKING_RESET     = 1'b0;
    localparam logic [2:0] DIV_FASTEST    = 3'h0;

    // Loop multiplies the crystal by this to make the master clock
    localparam logic [10:0] PLL_MULT = 11'h200;
    localparam logic [10:0] LOCK_TOL = 11'h008;

    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned XTAL_PERIOD_NS = 30518;
    localparam int unsigned LOSS_NS        = 2 * XTAL_PERIOD_NS;
    localparam int unsigned LOSS_CYCLES    = LOSS_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// [verilog/core_clock_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module core_clock_divider
    import clock_ctrl_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    core_div_if.div   dv
);
    logic [CNT_W-1:0] tick_cnt;
    logic [CNT_W-1:0] last_cnt;

    always_comb begin
        last_cnt = CNT_W'((1 << dv.active_sel) - 1);
    end

    // select swapped only at period end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt      <= '0;
            dv.active_sel <= DIV_RESET;
            dv.core_tick  <= 1'b0;
        end else begin
            dv.core_tick <= 1'b0;
            if (dv.master_tick && !dv.halt) begin
                if (tick_cnt == last_cnt) begin
                    tick_cnt      <= '0;
                    dv.core_tick  <= 1'b1;
                    dv.active_sel <= dv.sel;
                end else begin
                    tick_cnt <= tick_cnt + 1'b1;
                end
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_sel_at_boundary: assert property (
        $changed(dv.active_sel)
        |-> $past(dv.master_tick) && $past(tick_cnt) == $past(last_cnt))
        else $error("select changed mid period");
    a_tick_terminal: assert property (
        dv.core_tick
        |-> $past(tick_cnt) == $past(last_cnt) && $past(dv.master_tick) && !$past(dv.halt))
        else $error("core tick off count");
    a_halt_no_tick: assert property (
        $past(dv.halt) |-> !dv.core_tick)
        else $error("core tick while halted");
    c_div_seven: cover property (dv.core_tick && dv.active_sel == 3'h7);
endmodule // core_clock_divider
`default_nettype wire

// [verilog/core_clock_pll_control.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - With the halt bit set the crystal oscillator stops in power-down, otherwise it keeps running.
// - The tracking flag is read-only and hardware sets it after power-on when the loop tracks.
// - If the loop does not track at power-on the flag is cleared and the loop free-runs.
// - If the crystal is lost after lock the core clock halts.
// - With the fast bit set, interrupt service runs at the fastest core clock.
// - After the interrupt routine returns the core goes back to the selected divider.
// - The divider field divides the loop clock by two to the power of its value.
// - After reset the divider field selects code three.
// - The loop runs at 512 times the crystal frequency.
module core_clock_pll_control
    import clock_ctrl_pkg::*;
#(
    parameter int unsigned LOSS_LIMIT = LOSS_CYCLES
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    input  wire logic              xtal_in,
    input  wire logic              pll_tick,
    input  wire logic              sleep_req,
    input  wire logic              irq_active,
    output var  logic              core_tick,
    output var  logic              core_halt,
    output var  logic              osc_run,
    output var  logic              pll_locked
);
    typedef enum logic [2:0] {
        ST_WAIT_EDGE,
        ST_START,
        ST_MEASURE,
        ST_LOCKED,
        ST_FREE,
        ST_HALTED
    } lock_state_t;

    lock_state_t      lock_state;
    lock_state_t      next_lock_state;
    logic             oscillator_halt_in_sleep;
    logic             fast_irq_clocking;
    logic [DIV_W-1:0] core_divider_select;
    logic [2:0]       xtal_sync;
    logic             xtal_level;
    logic             xtal_rise;
    logic [10:0]      period_ticks;
    logic [15:0]      idle_cycles;
    logic             timed_out;
    logic             in_range;
    logic             addr_hit;
    logic             access_done;
    logic [7:0]       ctrl_value;

    core_div_if dvi ();

    core_clock_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .dv      (dvi.div)
    );

    // back to divider field after return
    assign dvi.sel         = (fast_irq_clocking && irq_active) ? DIV_FASTEST
                                                                : core_divider_select;
    assign dvi.master_tick = pll_tick;
    assign dvi.halt        = core_halt;
    assign core_tick       = dvi.core_tick;

    assign addr_hit    = (paddr == CTRL_ADDR);
    assign access_done = psel && penable && pready;
    assign ctrl_value  = {oscillator_halt_in_sleep, pll_locked, 2'b00,
                          fast_irq_clocking, core_divider_select};

    // APB answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !addr_hit;
            prdata  <= (addr_hit && !pwrite) ? {24'h000000, ctrl_value} : 32'h00000000;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oscillator_halt_in_sleep <= OSC_HALT_RESET;
            fast_irq_clocking        <= FAST_IRQ_CLOCKING_RESET;
            core_divider_select      <= DIV_RESET;
        end else if (access_done && pwrite && addr_hit) begin
            oscillator_halt_in_sleep <= pwdata[OSC_HALT_BIT];
            fast_irq_clocking        <= pwdata[FAST_IRQ_CLOCKING_BIT];
            core_divider_select      <= pwdata[DIV_MSB:DIV_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_run <= 1'b1;
        end else begin
            osc_run <= !(sleep_req && oscillator_halt_in_sleep);
        end
    end

    // Crystal pin is asynchronous; level moves once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_sync  <= 3'b000;
            xtal_level <= 1'b0;
        end else begin
            xtal_sync <= {xtal_sync[1:0], xtal_in};
            if (xtal_sync[1] == xtal_sync[2]) begin
                xtal_level <= xtal_sync[2];
            end
        end
    end

    assign xtal_rise = (xtal_sync[1] == xtal_sync[2]) && xtal_sync[2] && !xtal_level;
    assign timed_out = (idle_cycles >= 16'(LOSS_LIMIT));
    // expect 512 loop ticks per crystal period
    assign in_range  = (period_ticks >= PLL_MULT - LOCK_TOL)
                    && (period_ticks <= PLL_MULT + LOCK_TOL);

    // Saturating counters avoid wrap-around false locks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_ticks <= '0;
            idle_cycles  <= '0;
        end else if (xtal_rise) begin
            period_ticks <= '0;
            idle_cycles  <= '0;
        end else begin
            if (pll_tick && period_ticks != 11'h7FF) begin
                period_ticks <= period_ticks + 1'b1;
            end
            if (idle_cycles != 16'hFFFF) begin
                idle_cycles <= idle_cycles + 1'b1;
            end
        end
    end

    always_comb begin
        next_lock_state = lock_state;
        case (lock_state)
            // First rise may be false when the pin idles high
            ST_WAIT_EDGE: begin
                if (xtal_rise) begin
                    next_lock_state = ST_START;
                end else if (timed_out) begin
                    next_lock_state = ST_FREE;
                end
            end
            ST_START: begin
                if (xtal_rise) begin
                    next_lock_state = ST_MEASURE;
                end else if (timed_out) begin
                    next_lock_state = ST_FREE;
                end
            end
            ST_MEASURE: begin
                if (xtal_rise) begin
                    next_lock_state = in_range ? ST_LOCKED : ST_FREE;
                end else if (timed_out) begin
                    next_lock_state = ST_FREE;
                end
            end
            ST_LOCKED: begin
                if (timed_out) begin
                    next_lock_state = ST_HALTED;
                end
            end
            default: begin
                next_lock_state = lock_state;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_state <= ST_WAIT_EDGE;
        end else begin
            lock_state <= next_lock_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_locked <= 1'b0;
        end else if (next_lock_state == ST_LOCKED) begin
            pll_locked <= 1'b1;
        end else if (next_lock_state == ST_FREE) begin
            pll_locked <= 1'b0;
        end
    end

    // core stops once crystal is lost after lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_halt <= 1'b0;
        end else if (next_lock_state == ST_HALTED) begin
            core_halt <= 1'b1;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_osc_halt_gate: assert property (
        sleep_req && oscillator_halt_in_sleep |=> !osc_run)
        else $error("oscillator kept running");
    a_osc_keep_run: assert property (
        !(sleep_req && oscillator_halt_in_sleep) |=> osc_run)
        else $error("oscillator stopped");
    a_halt_bit_write: assert property (
        access_done && pwrite && addr_hit
        |=> oscillator_halt_in_sleep == $past(pwdata[OSC_HALT_BIT]))
        else $error("halt bit write lost");
    a_lock_set_track: assert property (
        lock_state == ST_MEASURE && xtal_rise && in_range
        |=> pll_locked && lock_state == ST_LOCKED)
        else $error("lock not set");
    a_lock_readback: assert property (
        access_done && !pwrite && addr_hit |-> prdata[LOCK_BIT] == $past(pll_locked))
        else $error("lock flag readback wrong");
    a_lock_clear_free: assert property (
        lock_state == ST_FREE |-> !pll_locked)
        else $error("lock set while free running");
    // free run is final and core keeps going
    a_free_sticky: assert property (
        lock_state == ST_FREE |=> lock_state == ST_FREE && !core_halt)
        else $error("free run left");
    a_halt_on_loss: assert property (
        lock_state == ST_LOCKED && timed_out
        |=> core_halt ##1 core_halt)
        else $error("core not halted");
    a_halt_after_lock: assert property (
        $rose(core_halt) |-> $past(lock_state) == ST_LOCKED)
        else $error("halt without lock");
    a_halt_sticky: assert property (
        core_halt |=> core_halt)
        else $error("halt released");
    a_rsvd_read_zero: assert property (
        access_done && !pwrite && addr_hit
        |-> prdata[5:4] == 2'b00 && prdata[31:8] == 24'h000000)
        else $error("reserved bits not zero");
    a_fast_irq_sel: assert property (
        dvi.core_tick && $past(fast_irq_clocking && irq_active)
        |-> dvi.active_sel == DIV_FASTEST)
        else $error("fast select missing");
    a_fast_off: assert property (
        dvi.core_tick && !$past(fast_irq_clocking)
        |-> dvi.active_sel == $past(core_divider_select))
        else $error("speed-up while disabled");
    a_resume_divider: assert property (
        dvi.core_tick && !$past(irq_active)
        |-> dvi.active_sel == $past(core_divider_select))
        else $error("divider not resumed");
    a_div_write: assert property (
        access_done && pwrite && addr_hit
        |=> core_divider_select == $past(pwdata[DIV_MSB:DIV_LSB]))
        else $error("divider write lost");
    a_reset_div_three: assert property (
        $rose(presetn) |-> core_divider_select == 3'h3)
        else $error("divider reset value wrong");
    // lock only from a measured period
    a_lock_rise_cause: assert property (
        $rose(pll_locked) |-> $past(lock_state == ST_MEASURE && xtal_rise && in_range))
        else $error("lock without measured period");
    a_lock_bit_ro: assert property (
        access_done && pwrite && addr_hit
        |=> pll_locked == $past(pll_locked) || lock_state != $past(lock_state))
        else $error("lock flag written");
    // Bus answers after one access cycle
    a_apb_answer: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing");
    // Unmapped offsets refused and read zero
    a_unmapped_err: assert property (
        psel && !penable && !addr_hit |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    c_locked: cover property (lock_state == ST_MEASURE ##1 lock_state == ST_LOCKED);
    c_free_run: cover property (lock_state == ST_FREE);
    c_halted: cover property (core_halt);
    c_fast_irq: cover property (fast_irq_clocking && irq_active && core_tick);
endmodule // core_clock_pll_control
`default_nettype wire

// [verilog/core_div_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface core_div_if;
    import clock_ctrl_pkg::*;
    logic             master_tick;
    logic             halt;
    logic [DIV_W-1:0] sel;
    logic             core_tick;
    logic [DIV_W-1:0] active_sel;

    modport ctrl (output master_tick, output halt, output sel,
                  input core_tick, input active_sel);
    modport div  (input master_tick, input halt, input sel,
                  output core_tick, output active_sel);
endinterface
`default_nettype wire
